// *** pwmd_top.sv ***
/*
  Pulse-width modulator unit: Avalon-MM register slave, clock divider,
  generators, output control and interrupt.
  Assumes a single system clock; pins need no further conditioning.
*/
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module pwmd_top #(
  parameter int NGEN = 4
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [2*NGEN-1:0] modulated_out,
  output logic [NGEN-1:0] trig_out,
  output logic irq
);
  localparam int NOUT = 2 * NGEN;
  localparam int NEVT = pwmd_pkg::EVT_N * NGEN;
  localparam logic [2:0] GPAGE = 3'(pwmd_pkg::ADDR_GEN_BASE >> pwmd_pkg::GEN_STRIDE_LOG2);

  // ==========================================================
  // Bus slave: one wait cycle, then the answer
  logic wait_r;
  logic [31:0] rdata_r;
  logic acc;
  logic wr_acc;
  logic rd_acc;
  assign acc = (avs_read || avs_write) && !wait_r;
  assign wr_acc = acc && avs_write;
  assign rd_acc = acc && avs_read;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      wait_r <= 1'b1;
    else
      wait_r <= !((avs_read || avs_write) && wait_r);
  end
  assign avs_waitrequest = wait_r;

  // ==========================================================
  // Common registers
  logic [2:0] div_sel_r;
  logic [NOUT-1:0] out_en_r;
  logic [NOUT-1:0] invert_r;
  logic [NEVT-1:0] int_stat_r;
  logic [NEVT-1:0] int_mask_r;
  logic [NGEN-1:0] sync_req_r;
  logic [NEVT-1:0] evt_all;
  logic [NOUT-1:0] raw_out;
  logic [NGEN-1:0] trig_all;
  logic [15:0] gcnt [NGEN];
  logic [NGEN-1:0] gen_irq;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      div_sel_r <= pwmd_pkg::RST_DIV_SEL;
      out_en_r <= '0;
      invert_r <= '0;
      int_mask_r <= '0;
    end
    else if (wr_acc)
    begin
      // Larger codes are clipped so the divider stays at 64 at most
      if (avs_address == pwmd_pkg::ADDR_CTRL)
        div_sel_r <= (avs_writedata[2:0] > pwmd_pkg::DIV_SEL_MAX) ?
          pwmd_pkg::DIV_SEL_MAX : avs_writedata[2:0];
      if (avs_address == pwmd_pkg::ADDR_OUT_EN)
        out_en_r <= avs_writedata[NOUT-1:0];
      if (avs_address == pwmd_pkg::ADDR_INVERT)
        invert_r <= avs_writedata[NOUT-1:0];
      if (avs_address == pwmd_pkg::ADDR_INT_MASK)
        int_mask_r <= avs_writedata[NEVT-1:0];
    end
  end

  // Sync request is a one-cycle pulse per generator
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      sync_req_r <= '0;
    else if (wr_acc && avs_address == pwmd_pkg::ADDR_SYNC)
      sync_req_r <= avs_writedata[NGEN-1:0];
    else
      sync_req_r <= '0;
  end

  // Read clears only the bits it returned, so an event landing in the wait cycle survives
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      int_stat_r <= '0;
    else if (rd_acc && avs_address == pwmd_pkg::ADDR_INT_STAT)
      int_stat_r <= (int_stat_r & ~rdata_r[NEVT-1:0]) | evt_all;
    else
      int_stat_r <= int_stat_r | evt_all;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      irq <= 1'b0;
    else
      irq <= |gen_irq;
  end

  // ==========================================================
  // Clock divider: one tick every 2^sel system clocks
  logic [5:0] div_cnt_r;
  logic tick_r;
  logic [5:0] div_top;
  assign div_top = 6'(({6'h0, 1'b1} << div_sel_r) - 7'h01);
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      div_cnt_r <= 6'h00;
      tick_r <= 1'b0;
    end
    else if (div_cnt_r >= div_top)
    begin
      div_cnt_r <= 6'h00;
      tick_r <= 1'b1;
    end
    else
    begin
      div_cnt_r <= div_cnt_r + 6'h01;
      tick_r <= 1'b0;
    end
  end

  // ==========================================================
  // Generators and their register blocks
  pwmd_gen_if gif[NGEN]();
  logic [7:0] gctrl_r [NGEN];
  logic [15:0] gload_r [NGEN];
  logic [15:0] gcmpa_r [NGEN];
  logic [15:0] gcmpb_r [NGEN];
  logic [15:0] gdbr_r [NGEN];
  logic [15:0] gdbf_r [NGEN];

  genvar gi;
  generate
    for (gi = 0; gi < NGEN; gi++)
    begin : gen_blk
      logic hit;
      logic [4:0] off;
      assign hit = wr_acc && (avs_address[7:5] == 3'(GPAGE + gi));
      assign off = avs_address[4:0];
      always_ff @(posedge clk_sys or negedge nrst)
      begin
        if (!nrst)
        begin
          gctrl_r[gi] <= pwmd_pkg::RST_GCTRL;
          gload_r[gi] <= pwmd_pkg::RST_LOAD;
          gcmpa_r[gi] <= pwmd_pkg::RST_CMP;
          gcmpb_r[gi] <= pwmd_pkg::RST_CMP;
          gdbr_r[gi] <= pwmd_pkg::RST_DB;
          gdbf_r[gi] <= pwmd_pkg::RST_DB;
        end
        else if (hit)
        begin
          if (off == pwmd_pkg::GOFF_CTRL)
            gctrl_r[gi] <= avs_writedata[7:0];
          if (off == pwmd_pkg::GOFF_LOAD)
            gload_r[gi] <= avs_writedata[15:0];
          if (off == pwmd_pkg::GOFF_CMPA)
            gcmpa_r[gi] <= avs_writedata[15:0];
          if (off == pwmd_pkg::GOFF_CMPB)
            gcmpb_r[gi] <= avs_writedata[15:0];
          if (off == pwmd_pkg::GOFF_DBRISE)
            gdbr_r[gi] <= avs_writedata[15:0];
          if (off == pwmd_pkg::GOFF_DBFALL)
            gdbf_r[gi] <= avs_writedata[15:0];
        end
      end
      assign gif[gi].tick = tick_r;
      assign gif[gi].sync_req = sync_req_r[gi];
      assign gif[gi].ctrl = gctrl_r[gi];
      assign gif[gi].load = gload_r[gi];
      assign gif[gi].cmpa = gcmpa_r[gi];
      assign gif[gi].cmpb = gcmpb_r[gi];
      assign gif[gi].db_rise = gdbr_r[gi];
      assign gif[gi].db_fall = gdbf_r[gi];
      assign gcnt[gi] = gif[gi].count;
      assign raw_out[2*gi] = gif[gi].out_a;
      assign raw_out[2*gi+1] = gif[gi].out_b;
      assign evt_all[4*gi +: 4] = gif[gi].evt;
      assign trig_all[gi] = gif[gi].trig;
      assign gen_irq[gi] = |(int_stat_r[4*gi +: 4] & int_mask_r[4*gi +: 4]);
      pwmd_gen u_gen (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .g(gif[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Output control: polarity, then gating; gated pins sit low
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      modulated_out <= '0;
      trig_out <= '0;
    end
    else
    begin
      modulated_out <= (raw_out ^ invert_r) & out_en_r;
      trig_out <= trig_all;
    end
  end

  // ==========================================================
  // Read mux, latched in the wait cycle
  logic [31:0] rmux;
  always_comb
  begin
    rmux = 32'h0000_0000;
    if (avs_address == pwmd_pkg::ADDR_CTRL)
      rmux = {29'h0, div_sel_r};
    else if (avs_address == pwmd_pkg::ADDR_OUT_EN)
      rmux = 32'(out_en_r);
    else if (avs_address == pwmd_pkg::ADDR_INVERT)
      rmux = 32'(invert_r);
    else if (avs_address == pwmd_pkg::ADDR_INT_STAT)
      rmux = 32'(int_stat_r);
    else if (avs_address == pwmd_pkg::ADDR_INT_MASK)
      rmux = 32'(int_mask_r);
    for (int i = 0; i < NGEN; i++)
    begin
      if (avs_address[7:5] == 3'(GPAGE + i))
      begin
        unique case (avs_address[4:0])
          pwmd_pkg::GOFF_CTRL: rmux = {24'h0, gctrl_r[i]};
          pwmd_pkg::GOFF_LOAD: rmux = {16'h0, gload_r[i]};
          pwmd_pkg::GOFF_CMPA: rmux = {16'h0, gcmpa_r[i]};
          pwmd_pkg::GOFF_CMPB: rmux = {16'h0, gcmpb_r[i]};
          pwmd_pkg::GOFF_DBRISE: rmux = {16'h0, gdbr_r[i]};
          pwmd_pkg::GOFF_DBFALL: rmux = {16'h0, gdbf_r[i]};
          pwmd_pkg::GOFF_COUNT: rmux = {16'h0, gcnt[i]};
          default: rmux = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      rdata_r <= 32'h0000_0000;
    else if (avs_read && wait_r)
      rdata_r <= rmux;
  end
  assign avs_readdata = rdata_r;
endmodule : pwmd_top

// *** pwmd_pkg.sv ***
/*
  Constants shared by the pulse-width modulator: register map, field
  positions, reset values and divider limits.
  Assumes a 32-bit Avalon-MM slave with byte addresses on 8 bits.
*/
// How it works
// - Per generator: 16-bit counter, two comparators
// - Up to four generators, one output control
// - Two outputs: independent or complementary with dead-band
// - Each generator has interrupt and trigger output
// - Control sets polarity and per-output pin enable
// - Generator n drives outputs 2n and 2n+1
// - Modulator clock is system clock / 1..64
// - Divided tick times period, width and dead-band
// - Divider setting reads back
// - Dead-band off: channels follow own comparators
// - Rise and fall delays counted from first channel
// - Dead-band on: second channel derives from first
// - One or two instances, three or four generators
// - Down mode: load down to zero, then reload
// - Up/down mode: zero to load and back
// - New period and width apply at zero
// - Sync mode: hold values until sync event
package pwmd_pkg;
  // ==========================================================
  // Widths and limits
  localparam int CNT_W = 16;
  localparam int DIV_SEL_W = 3;
  localparam logic [2:0] DIV_SEL_MAX = 3'h6;
  localparam int DIV_CNT_W = 6;
  localparam int EVT_N = 4;
  // ==========================================================
  // Common registers (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OUT_EN = 8'h04;
  localparam logic [7:0] ADDR_INVERT = 8'h08;
  localparam logic [7:0] ADDR_INT_STAT = 8'h0c;
  localparam logic [7:0] ADDR_INT_MASK = 8'h10;
  localparam logic [7:0] ADDR_SYNC = 8'h14;
  // Per-generator blocks: base plus index times stride
  localparam logic [7:0] ADDR_GEN_BASE = 8'h40;
  localparam int GEN_STRIDE_LOG2 = 5;
  localparam logic [4:0] GOFF_CTRL = 5'h00;
  localparam logic [4:0] GOFF_LOAD = 5'h04;
  localparam logic [4:0] GOFF_CMPA = 5'h08;
  localparam logic [4:0] GOFF_CMPB = 5'h0c;
  localparam logic [4:0] GOFF_DBRISE = 5'h10;
  localparam logic [4:0] GOFF_DBFALL = 5'h14;
  localparam logic [4:0] GOFF_COUNT = 5'h18;
  // ==========================================================
  // Generator control fields
  localparam int GC_ENABLE = 0;
  localparam int GC_UPDOWN = 1;
  localparam int GC_SYNC = 2;
  localparam int GC_DBEN = 3;
  localparam int GC_TRIG_LSB = 4;
  // Event order inside a generator: zero, load, cmp one, cmp two
  localparam int EV_ZERO = 0;
  localparam int EV_LOAD = 1;
  localparam int EV_CMPA = 2;
  localparam int EV_CMPB = 3;
  // ==========================================================
  // Reset values
  localparam logic [2:0] RST_DIV_SEL = 3'h0;
  localparam logic [7:0] RST_GCTRL = 8'h00;
  localparam logic [15:0] RST_LOAD = 16'hffff;
  localparam logic [15:0] RST_CMP = 16'h0000;
  localparam logic [15:0] RST_DB = 16'h0000;
endpackage : pwmd_pkg

// *** pwmd_gen_if.sv ***
/*
  Carrier between the register block and one generator.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface pwmd_gen_if;
  logic tick;
  logic sync_req;
  logic [7:0] ctrl;
  logic [15:0] load;
  logic [15:0] cmpa;
  logic [15:0] cmpb;
  logic [15:0] db_rise;
  logic [15:0] db_fall;
  logic [15:0] count;
  logic out_a;
  logic out_b;
  logic [3:0] evt;
  logic trig;
  modport ctl (output tick, sync_req, ctrl, load, cmpa, cmpb, db_rise, db_fall,
    input count, out_a, out_b, evt, trig);
  modport gen (input tick, sync_req, ctrl, load, cmpa, cmpb, db_rise, db_fall,
    output count, out_a, out_b, evt, trig);
endinterface : pwmd_gen_if

// *** pwmd_gen.sv ***
/*
  One generator: counter, two comparators, dead-band and events.
  Assumes tick is a one-cycle pulse from the shared clock divider.
*/
`timescale 1ns/1ps
module pwmd_gen (
  input wire logic clk_sys,
  input wire logic nrst,
  pwmd_gen_if.gen g
);
  // ==========================================================
  // Counter with zero-aligned updates
  logic [15:0] cnt_r;
  logic dir_down_r;
  logic [15:0] load_r;
  logic [15:0] cmpa_r;
  logic [15:0] cmpb_r;
  logic pend_r;
  logic en;
  logic updown;
  logic upd;
  logic at_zero;
  assign en = g.ctrl[pwmd_pkg::GC_ENABLE];
  assign updown = g.ctrl[pwmd_pkg::GC_UPDOWN];
  assign at_zero = (cnt_r == 16'h0000);
  // Sync mode waits for a sync event; either mode waits for zero
  assign upd = at_zero && (!g.ctrl[pwmd_pkg::GC_SYNC] || pend_r);

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      pend_r <= 1'b0;
    else if (g.sync_req)
      pend_r <= 1'b1;
    else if (g.tick && upd)
      pend_r <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      load_r <= pwmd_pkg::RST_LOAD;
      cmpa_r <= pwmd_pkg::RST_CMP;
      cmpb_r <= pwmd_pkg::RST_CMP;
    end
    else if (!en || (g.tick && upd))
    begin
      load_r <= g.load;
      cmpa_r <= g.cmpa;
      cmpb_r <= g.cmpb;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_r <= 16'h0000;
      dir_down_r <= 1'b0;
    end
    else if (!en)
    begin
      cnt_r <= 16'h0000;
      dir_down_r <= 1'b0;
    end
    else if (g.tick)
    begin
      if (!updown)
      begin
        dir_down_r <= 1'b1;
        cnt_r <= at_zero ? (upd ? g.load : load_r) : cnt_r - 16'h0001;
      end
      else if (!dir_down_r)
      begin
        if (cnt_r >= load_r)
        begin
          dir_down_r <= 1'b1;
          cnt_r <= cnt_r - 16'h0001;
        end
        else
          cnt_r <= cnt_r + 16'h0001;
      end
      else if (at_zero)
      begin
        dir_down_r <= 1'b0;
        cnt_r <= 16'h0001;
      end
      else
        cnt_r <= cnt_r - 16'h0001;
    end
  end
  assign g.count = cnt_r;

  // ==========================================================
  // Comparators: left aligned in down mode, centred in up/down
  logic raw_a;
  logic raw_b;
  assign raw_a = en && (updown ? (cnt_r < cmpa_r) : (cnt_r > cmpa_r));
  assign raw_b = en && (updown ? (cnt_r < cmpb_r) : (cnt_r > cmpb_r));

  // ==========================================================
  // Events, interrupt sources and trigger
  logic [3:0] evt_r;
  logic trig_r;
  logic [3:0] evt_now;
  assign evt_now = {cnt_r == cmpb_r, cnt_r == cmpa_r, cnt_r == load_r, at_zero};
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      evt_r <= 4'h0;
      trig_r <= 1'b0;
    end
    else
    begin
      evt_r <= (en && g.tick) ? evt_now : 4'h0;
      trig_r <= en && g.tick && |(evt_now & g.ctrl[7:4]);
    end
  end
  assign g.evt = evt_r;
  assign g.trig = trig_r;

  // ==========================================================
  // Dead-band: second channel is the delayed complement of the first
  logic a_prev_r;
  logic [15:0] db_cnt_r;
  logic out_a_r;
  logic out_b_r;
  logic rise;
  logic fall;
  assign rise = raw_a && !a_prev_r;
  assign fall = !raw_a && a_prev_r;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      a_prev_r <= 1'b0;
      db_cnt_r <= 16'h0000;
      out_a_r <= 1'b0;
      out_b_r <= 1'b0;
    end
    else
    begin
      a_prev_r <= raw_a;
      if (!g.ctrl[pwmd_pkg::GC_DBEN])
      begin
        out_a_r <= raw_a;
        out_b_r <= raw_b;
        db_cnt_r <= 16'h0000;
      end
      else if (rise)
      begin
        out_b_r <= 1'b0;
        db_cnt_r <= g.db_rise;
        out_a_r <= (g.db_rise == 16'h0000);
      end
      else if (fall)
      begin
        out_a_r <= 1'b0;
        db_cnt_r <= g.db_fall;
        out_b_r <= en && (g.db_fall == 16'h0000);
      end
      else if (g.tick && db_cnt_r != 16'h0000)
      begin
        db_cnt_r <= db_cnt_r - 16'h0001;
        if (db_cnt_r == 16'h0001)
        begin
          if (raw_a)
            out_a_r <= 1'b1;
          else
            out_b_r <= en;
        end
      end
    end
  end
  assign g.out_a = out_a_r;
  assign g.out_b = out_b_r;
endmodule : pwmd_gen

// *** pwmd_top_asserts.sv ***
/*
  Checker for the modulator top: bus handshake, readback, pin gating,
  interrupt and trigger qualification, dead-band separation.
  Assumes it sees only the top ports and shadows register writes itself.
*/
`timescale 1ns/1ps
module pwmd_top_asserts #(
  parameter int NGEN = 4
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [2*NGEN-1:0] modulated_out,
  input wire logic [NGEN-1:0] trig_out,
  input wire logic irq
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  // ====================
  // Shadows of written registers
  localparam logic [7:0] A_GC = pwmd_pkg::ADDR_GEN_BASE;
  localparam logic [7:0] A_HOLE = 8'(64 + 32 * NGEN);
  logic wr_ok;
  logic rd_ok;
  logic [2:0] div_s;
  logic [2*NGEN-1:0] en_s;
  logic [1:0] inv_s;
  logic [4*NGEN-1:0] mask_s;
  logic [7:0] gc_s;
  logic [3:0] age_r;
  assign wr_ok = avs_write && !avs_waitrequest;
  assign rd_ok = avs_read && !avs_waitrequest;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      div_s <= '0;
      en_s <= '0;
      inv_s <= '0;
      mask_s <= '0;
      gc_s <= '0;
    end
    else if (wr_ok)
    begin
      case (avs_address)
        pwmd_pkg::ADDR_CTRL: div_s <= (avs_writedata[2:0] > pwmd_pkg::DIV_SEL_MAX) ?
          pwmd_pkg::DIV_SEL_MAX : avs_writedata[2:0];
        pwmd_pkg::ADDR_OUT_EN: en_s <= avs_writedata[2*NGEN-1:0];
        pwmd_pkg::ADDR_INVERT: inv_s <= avs_writedata[1:0];
        pwmd_pkg::ADDR_INT_MASK: mask_s <= avs_writedata[4*NGEN-1:0];
        A_GC: gc_s <= avs_writedata[7:0];
        default: ;
      endcase
    end
  end
  // Mode or polarity changes glitch the pair; judge only after a quiet run
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      age_r <= '0;
    else if (wr_ok && (avs_address == A_GC || avs_address == pwmd_pkg::ADDR_INVERT))
      age_r <= '0;
    else if (age_r != 4'hf)
      age_r <= age_r + 4'h1;
  end
  // ====================
  // Properties
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  a_wait_one: assert property (s_req |=> s_answer)
    else $error("wait not one cycle");
  a_reset_quiet: assert property ($rose(nrst) |->
    avs_waitrequest && modulated_out == '0 && trig_out == '0 && !irq)
    else $error("outputs active after reset");
  a_ctrl_readback: assert property (rd_ok && avs_address == pwmd_pkg::ADDR_CTRL |->
    avs_readdata[2:0] == div_s) else $error("divide select readback");
  a_hole_zero: assert property (rd_ok && avs_address == A_HOLE |-> avs_readdata == '0)
    else $error("unmapped read not zero");
  a_pin_gated: assert property ((modulated_out & ~($past(en_s) | $past(en_s, 2))) == '0)
    else $error("disabled pin high");
  a_irq_masked: assert property (irq |-> ($past(mask_s) | $past(mask_s, 2)) != '0)
    else $error("irq with all masked");
  a_trig_enabled: assert property (trig_out[0] |->
    ($past(gc_s[7:4]) | $past(gc_s[7:4], 2) | $past(gc_s[7:4], 3)) != 4'h0)
    else $error("trigger without enabled event");
  a_dead_apart: assert property (age_r == 4'hf && gc_s[3] && inv_s == 2'h0 |->
    !(modulated_out[0] && modulated_out[1])) else $error("pair high together");
endmodule : pwmd_top_asserts
bind pwmd_top pwmd_top_asserts #(.NGEN(NGEN)) u_asserts (.clk_sys(clk_sys), .nrst(nrst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .modulated_out(modulated_out),
  .trig_out(trig_out), .irq(irq));

// *** pwmd_stage_model.sv ***
/*
  Power stage model: one half-bridge leg on pins 0 and 1; on-time counted on every pin.
  Assumes pins are sampled on the system clock while run is high.
*/
`timescale 1ns/1ps
module pwmd_stage_model #(
  parameter int NOUT = 8
) (
  input wire logic clk_sys,
  input wire logic clr,
  input wire logic run,
  input wire logic [NOUT-1:0] gate_in,
  input wire logic trig_in
);
  // ====================
  // On-time, trigger and shoot-through counts
  int unsigned hi_cnt [NOUT];
  int unsigned trig_cnt;
  int unsigned clash_cnt;
  always @(posedge clk_sys)
  begin
    for (int i = 0; i < NOUT; i++)
      hi_cnt[i] <= clr ? 0 : hi_cnt[i] + (run && gate_in[i] === 1'b1);
    trig_cnt <= clr ? 0 : trig_cnt + (run && trig_in === 1'b1);
    // Both switches of one leg on shorts the supply
    clash_cnt <= clr ? 0 : clash_cnt + (run && gate_in[1:0] === 2'h3);
  end
endmodule : pwmd_stage_model

// *** testbench.sv ***
/*
  Bench for the modulator unit: registers, waveforms, divider, polarity,
  gating, dead-band, sync update, interrupt and trigger.
  Assumes the stage model counts pin high cycles between clr and run.
*/
`timescale 1ns/1ps
module testbench;
  // ====================
  // Signals
  localparam int NG = 4;
  localparam logic [7:0] A_GC = pwmd_pkg::ADDR_GEN_BASE;
  localparam logic [7:0] A_LD = A_GC + {3'h0, pwmd_pkg::GOFF_LOAD};
  localparam logic [7:0] A_CA = A_GC + {3'h0, pwmd_pkg::GOFF_CMPA};
  localparam logic [7:0] A_CB = A_GC + {3'h0, pwmd_pkg::GOFF_CMPB};
  localparam logic [7:0] A_DR = A_GC + {3'h0, pwmd_pkg::GOFF_DBRISE};
  localparam logic [7:0] A_DF = A_GC + {3'h0, pwmd_pkg::GOFF_DBFALL};
  localparam logic [7:0] A_CN = A_GC + {3'h0, pwmd_pkg::GOFF_COUNT};
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] avs_address = 8'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [2*NG-1:0] modulated_out;
  logic [NG-1:0] trig_out;
  logic irq;
  logic clr = 1'b1;
  logic run = 1'b0;
  logic [31:0] rd;
  int n_errors = 0;
  int checks_done = 0;
  always #2 clk_sys = ~clk_sys;
  pwmd_top #(.NGEN(NG)) dut (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .modulated_out(modulated_out), .trig_out(trig_out), .irq(irq));
  pwmd_stage_model #(.NOUT(2 * NG)) stage (.clk_sys(clk_sys), .clr(clr), .run(run),
    .gate_in(modulated_out), .trig_in(trig_out[0]));
  // ====================
  // Tasks
  task automatic end_sim();
    $display("mismatches %0d, comparisons %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: reg %h expected %h", $time, got, exp);
    end
  endtask : chk32
  task automatic chk_cnt(input int unsigned got, input int unsigned exp);
    checks_done++;
    if (got != exp)
    begin
      n_errors++;
      $display("wrong value at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask : chk_cnt
  // Request held until waitrequest is seen low; one idle edge keeps drivers clean
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    for (i = 0; i < 16; i++)
    begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0)
        break;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
    if (i == 16)
    begin
      n_errors++;
      $display("wrong value at %0t: bus timeout", $time);
      end_sim();
    end
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk32(rd, e);
  endtask : rchk
  // Windows are whole periods, so the counts do not depend on phase
  task automatic meas(input int cyc, input int e0, input int e1, input int et);
    repeat (40) @(posedge clk_sys);
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    run <= 1'b1;
    repeat (cyc) @(posedge clk_sys);
    run <= 1'b0;
    @(posedge clk_sys);
    chk_cnt(stage.hi_cnt[0], e0);
    chk_cnt(stage.hi_cnt[1], e1);
    chk_cnt(stage.trig_cnt, et);
  endtask : meas
  // ====================
  // Sequence
  initial
  begin
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    for (int g = 0; g < NG; g++)
      rchk(A_LD + 8'(32 * g), 32'hffff);
    rchk(A_CA, 32'h0);
    rchk(8'(64 + 32 * NG), 32'h0);
    wr(A_CN, 32'h1234);
    rchk(A_CN, 32'h0);
    for (int v = 0; v < 8; v++)
    begin
      wr(pwmd_pkg::ADDR_CTRL, 32'(v));
      rchk(pwmd_pkg::ADDR_CTRL, (v > 6) ? 32'h6 : 32'(v));
    end
    wr(pwmd_pkg::ADDR_CTRL, 32'h0);
    wr(pwmd_pkg::ADDR_OUT_EN, 32'hff);
    wr(A_LD, 32'h9);
    wr(A_CA, 32'h4);
    wr(A_CB, 32'h6);
    wr(A_GC, 32'h11);
    meas(100, 50, 30, 10);
    chk_cnt(stage.hi_cnt[2], 0);
    wr(pwmd_pkg::ADDR_CTRL, 32'h1);
    meas(200, 100, 60, 10);
    wr(pwmd_pkg::ADDR_CTRL, 32'h0);
    wr(pwmd_pkg::ADDR_INVERT, 32'h2);
    meas(100, 50, 70, 10);
    wr(pwmd_pkg::ADDR_OUT_EN, 32'h1);
    meas(100, 50, 0, 10);
    wr(pwmd_pkg::ADDR_INVERT, 32'h0);
    wr(pwmd_pkg::ADDR_OUT_EN, 32'hff);
    rchk(pwmd_pkg::ADDR_INT_STAT, 32'hf);
    chk32({31'h0, irq}, 32'h0);
    wr(pwmd_pkg::ADDR_INT_MASK, 32'h1);
    repeat (12) @(posedge clk_sys);
    chk32({31'h0, irq}, 32'h1);
    wr(A_GC, 32'h0);
    bus(1'b0, pwmd_pkg::ADDR_INT_STAT, 32'h0);
    rchk(pwmd_pkg::ADDR_INT_STAT, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk32({31'h0, irq}, 32'h0);
    wr(A_LD, 32'h5);
    wr(A_CA, 32'h3);
    wr(A_CB, 32'h1);
    wr(A_GC, 32'h3);
    meas(100, 50, 10, 0);
    wr(A_GC, 32'h0);
    wr(A_LD, 32'h9);
    wr(A_CA, 32'h4);
    wr(A_CB, 32'h0);
    wr(A_DR, 32'h1);
    wr(A_DF, 32'h2);
    wr(A_GC, 32'h9);
    meas(100, 40, 30, 0);
    chk_cnt(stage.clash_cnt, 0);
    wr(A_GC, 32'h1);
    meas(100, 50, 90, 0);
    wr(A_GC, 32'h5);
    wr(A_CA, 32'h2);
    meas(100, 50, 90, 0);
    wr(pwmd_pkg::ADDR_SYNC, 32'h1);
    meas(100, 70, 90, 0);
    wr(A_LD + 8'h20, 32'h9);
    wr(A_CA + 8'h20, 32'h2);
    wr(A_CB + 8'h20, 32'h4);
    wr(A_GC + 8'h20, 32'h1);
    meas(100, 70, 90, 0);
    chk_cnt(stage.hi_cnt[2], 70);
    chk_cnt(stage.hi_cnt[3], 50);
    end_sim();
  end
endmodule : testbench
